// ===== logic/mode_supply_control_regs.sv
// Mode, supply and hardware configuration control registers
// How it works
// (R1) Mode bits 7:6: normal, sleep, stop, or 11 triggers soft reset.
// (R2) Soft reset pulls reset output low unless soft-reset mask bit set.
// (R3) Mode register bit 5 enables the external-pass regulator.
// (R4) Aux field selects off, normal, normal+stop, or always except fail-safe.
// (R5) Overvoltage always sets flag; bit 2 also requests restart.
// (R6) Bits 1:0 select one of four reset thresholds, 00 highest.
// (R7) A serial request from stop to sleep is ignored.
// (R8) Entering restart loads normal mode into the mode field.
// (R9) Restart or overtemperature clears aux field to off.
// (R10) Read-back during a write shows the previously written value.
// (R11) Mode register zero on reset; restart keeps bits 5 and 1:0.
// (R12) Hardware bit 7 selects external-pass voltage.
// (R13) Hardware bit 5 activates fault outputs from software.
// (R14) Clearing software bit keeps failure-triggered fault outputs active.
// (R15) Restart clears software fault bit and its outputs.
// (R16) Hardware bit 4 keeps external-pass on under supply undervoltage.
// (R17) Hardware bit 3 selects load sharing with main regulator.
// (R18) Hardware bit 1 enables load sharing in stop and high power.
// (R19) Hardware bit 0 selects first or second watchdog failure.
// (R20) Hardware register zero on power-on; soft reset keeps 7, 6, 3, 0.
// (R21) Restart clears hardware bits 5, 2 and 1.
// (R22) Hardware bit 2 reads zero and ignores writes.
// (R23) Frame: 7-bit address, access bit, then data byte.
// (R24) Access bit 1 writes, 0 only reads.
// (R25) Writes apply only after a complete frame and deselect.
`timescale 1ns/1ps
module mode_supply_control_regs
  import supply_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic csn_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic restart_entry,
  input wire logic overtemp_event,
  input wire logic overvoltage_event,
  input wire logic ov_flag_clear,
  input wire logic failure_status,
  input wire logic fail_safe_active,
  input wire logic supply_undervoltage,
  input wire logic high_power_active,
  output logic [1:0] op_mode,
  output logic soft_reset_active,
  output logic reset_output_o,
  output logic reset_output_oe,
  output logic ext_pass_enable,
  output logic ext_pass_voltage_select,
  output logic ext_pass_load_share,
  output logic load_share_stop_enable,
  output logic aux_regulator_on,
  output logic [1:0] reset_threshold_select,
  output logic main_overvoltage_flag,
  output logic overvoltage_restart_req,
  output logic fault_outputs,
  output logic wd_first_fail_select
);
  typedef struct packed {
    logic [7:0] mode_supply;
    logic [7:0] hw_config;
    logic ov_flag;
    logic ov_req;
    logic sr_active;
    logic sr_drive;
    logic [7:0] sr_count;
  } ctrl_state_t;

  ctrl_state_t s_reg, s_next;

  logic [6:0] header_addr;
  logic [7:0] read_data;
  logic frame_valid;
  logic frame_write;
  logic [6:0] frame_addr;
  logic [7:0] frame_data;
  logic [1:0] cur_mode;
  logic [1:0] req_mode;

  serial_frame_port u_port (
    .clk(clk),
    .nrst(nrst),
    .csn_n(csn_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .header_addr(header_addr),
    .read_data(read_data),
    .frame_valid(frame_valid),
    .frame_write(frame_write),
    .frame_addr(frame_addr),
    .frame_data(frame_data)
  );

  // Read-back mux; unmapped addresses read zero
  always_comb begin
    unique case (header_addr)
      MODE_SUPPLY_ADDR: read_data = s_reg.mode_supply;
      HW_CONFIG_ADDR: read_data = s_reg.hw_config & HW_WRITE_MASK; // (R22)
      default: read_data = 8'h00;
    endcase
  end

  assign cur_mode = s_reg.mode_supply[MODE_HI:MODE_LO];
  assign req_mode = frame_data[MODE_HI:MODE_LO];

  always_comb begin
    s_next = s_reg;
    s_next.ov_req = 1'b0;
    // Soft reset pulse countdown
    if (s_reg.sr_active) begin
      if (s_reg.sr_count == 8'h01) begin
        s_next.sr_active = 1'b0;
        s_next.sr_drive = 1'b0;
        s_next.sr_count = 8'h00;
      end else begin
        s_next.sr_count = s_reg.sr_count - 8'h01;
      end
    end
    // Register writes from complete frames
    if (frame_valid && frame_write) begin // (R24)
      if (frame_addr == MODE_SUPPLY_ADDR) begin
        if (op_mode_t'(req_mode) == MODE_SOFT_RESET) begin // (R1)
          // Soft reset: registers take their soft reset values
          s_next.mode_supply = MODE_SUPPLY_RESET; // (R11)
          s_next.hw_config = s_reg.hw_config & HW_SOFT_KEEP; // (R20)
          s_next.sr_active = 1'b1;
          s_next.sr_drive = !s_reg.hw_config[SOFT_RESET_MASK_BIT]; // (R2)
          s_next.sr_count = SOFT_RESET_COUNT;
        end else begin
          s_next.mode_supply = frame_data;
          if (op_mode_t'(cur_mode) == MODE_STOP && op_mode_t'(req_mode) == MODE_SLEEP) begin
            s_next.mode_supply[MODE_HI:MODE_LO] = cur_mode; // (R7)
          end
        end
      end else if (frame_addr == HW_CONFIG_ADDR) begin
        s_next.hw_config = frame_data & HW_WRITE_MASK; // (R22)
      end
    end
    // Overtemperature turns the aux regulator off
    if (overtemp_event) begin
      s_next.mode_supply[AUX_SEL_HI:AUX_SEL_LO] = AUX_OFF; // (R9)
    end
    // Restart entry overrides any register write in the same cycle, but a soft reset write there still starts its pulse
    if (restart_entry) begin
      s_next.mode_supply = s_reg.mode_supply & MODE_RESTART_KEEP; // (R11)
      s_next.mode_supply[MODE_HI:MODE_LO] = MODE_NORMAL; // (R8)
      s_next.mode_supply[AUX_SEL_HI:AUX_SEL_LO] = AUX_OFF; // (R9)
      s_next.hw_config = s_reg.hw_config & HW_RESTART_KEEP; // (R21)
      s_next.hw_config[FAULT_SW_BIT] = 1'b0; // (R15)
    end
    // Overvoltage flag: set wins over clear
    if (ov_flag_clear) begin
      s_next.ov_flag = 1'b0;
    end
    if (overvoltage_event) begin
      s_next.ov_flag = 1'b1; // (R5)
      s_next.ov_req = s_reg.mode_supply[OV_RESTART_BIT]; // (R5)
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Aux regulator on/off from selection and current mode
  always_comb begin
    unique case (s_reg.mode_supply[AUX_SEL_HI:AUX_SEL_LO]) // (R4)
      AUX_OFF: aux_regulator_on = 1'b0;
      AUX_NORMAL_ONLY: aux_regulator_on = (op_mode_t'(cur_mode) == MODE_NORMAL);
      AUX_NORMAL_STOP: aux_regulator_on = (op_mode_t'(cur_mode) == MODE_NORMAL)
        || (op_mode_t'(cur_mode) == MODE_STOP);
      AUX_ALWAYS: aux_regulator_on = !fail_safe_active;
    endcase
  end

  assign op_mode = cur_mode; // (R1)
  assign soft_reset_active = s_reg.sr_active;
  // Open-drain reset output, only ever pulled low
  assign reset_output_o = 1'b0;
  assign reset_output_oe = s_reg.sr_drive; // (R2)
  assign ext_pass_enable = s_reg.mode_supply[EXT_PASS_ENABLE_BIT] // (R3)
    && (!supply_undervoltage || s_reg.hw_config[UV_KEEP_BIT]); // (R16)
  assign ext_pass_voltage_select = s_reg.hw_config[EXT_VOLT_SEL_BIT]; // (R12)
  assign ext_pass_load_share = s_reg.hw_config[LOAD_SHARE_BIT]; // (R17)
  assign load_share_stop_enable = s_reg.hw_config[LOAD_SHARE_BIT]
    && s_reg.hw_config[LS_STOP_BIT]
    && ((op_mode_t'(cur_mode) == MODE_STOP) || high_power_active); // (R18)
  assign reset_threshold_select = s_reg.mode_supply[THRESH_HI:THRESH_LO]; // (R6)
  assign main_overvoltage_flag = s_reg.ov_flag;
  assign overvoltage_restart_req = s_reg.ov_req;
  // Failure-triggered activation is independent of the software bit
  assign fault_outputs = s_reg.hw_config[FAULT_SW_BIT] || failure_status; // (R13) (R14)
  assign wd_first_fail_select = s_reg.hw_config[WD_FIRST_FAIL_BIT]; // (R19)
endmodule

// ===== logic/supply_ctrl_pkg.sv
// Constants for the mode and supply control register pair
package supply_ctrl_pkg;
  // Serial frame layout, first bit on the wire is bit 0
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] HEADER_LEN = 5'h08;
  // Register addresses
  localparam logic [6:0] MODE_SUPPLY_ADDR = 7'h01;
  localparam logic [6:0] HW_CONFIG_ADDR = 7'h02;
  // Mode and supply control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int EXT_PASS_ENABLE_BIT = 5;
  localparam int AUX_SEL_HI = 4;
  localparam int AUX_SEL_LO = 3;
  localparam int OV_RESTART_BIT = 2;
  localparam int THRESH_HI = 1;
  localparam int THRESH_LO = 0;
  // Hardware configuration fields
  localparam int EXT_VOLT_SEL_BIT = 7;
  localparam int SOFT_RESET_MASK_BIT = 6;
  localparam int FAULT_SW_BIT = 5;
  localparam int UV_KEEP_BIT = 4;
  localparam int LOAD_SHARE_BIT = 3;
  localparam int RESERVED_BIT = 2;
  localparam int LS_STOP_BIT = 1;
  localparam int WD_FIRST_FAIL_BIT = 0;
  // Values after power-on and soft reset, and bits kept on each event
  localparam logic [7:0] MODE_SUPPLY_RESET = 8'h00;
  localparam logic [7:0] HW_CONFIG_RESET = 8'h00;
  localparam logic [7:0] MODE_RESTART_KEEP = 8'h23;
  localparam logic [7:0] HW_SOFT_KEEP = 8'hc9;
  localparam logic [7:0] HW_RESTART_KEEP = 8'hd9;
  localparam logic [7:0] HW_WRITE_MASK = 8'hfb;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_STOP = 2'b10,
    MODE_SOFT_RESET = 2'b11
  } op_mode_t;
  // Aux regulator selections
  localparam logic [1:0] AUX_OFF = 2'b00;
  localparam logic [1:0] AUX_NORMAL_ONLY = 2'b01;
  localparam logic [1:0] AUX_NORMAL_STOP = 2'b10;
  localparam logic [1:0] AUX_ALWAYS = 2'b11;
  // Soft reset pulse length on the reset output
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SOFT_RESET_TIME_NS = 1000;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] SOFT_RESET_COUNT = 8'(SOFT_RESET_CYCLES);
endpackage

// ===== logic/serial_frame_port.sv
// Serial frame receiver and read-back shifter
`timescale 1ns/1ps
module serial_frame_port
  import supply_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic csn_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic [6:0] header_addr,
  input wire logic [7:0] read_data,
  output logic frame_valid,
  output logic frame_write,
  output logic [6:0] frame_addr,
  output logic [7:0] frame_data
);
  typedef struct packed {
    logic sclk_prev;
    logic csn_prev;
    logic [4:0] count;
    logic [15:0] shift;
    logic [7:0] tx;
    logic sdo;
  } port_state_t;

  port_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.sclk_prev = sclk;
    s_next.csn_prev = csn_n;
    if (csn_n) begin
      s_next.count = 5'h00;
      s_next.sdo = 1'b0;
    end else begin
      if (sclk && !s_reg.sclk_prev) begin
        s_next.shift = {sdi, s_reg.shift[15:1]};
        if (s_reg.count <= FRAME_LEN) begin
          s_next.count = s_reg.count + 5'h01;
        end
      end
      if (!sclk && s_reg.sclk_prev) begin
        if (s_reg.count == HEADER_LEN) begin
          // Snapshot before any commit, so a write shows the old value
          s_next.tx = {1'b0, read_data[7:1]}; // (R10)
          s_next.sdo = read_data[0]; // (R10)
        end else if (s_reg.count > HEADER_LEN) begin
          s_next.tx = {1'b0, s_reg.tx[7:1]};
          s_next.sdo = s_reg.tx[0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sdo = s_reg.sdo;
  assign sdo_oe = !csn_n;
  assign header_addr = s_reg.shift[14:8];
  // Commit only on deselect after exactly one full frame
  assign frame_valid = csn_n && !s_reg.csn_prev && (s_reg.count == FRAME_LEN); // (R25)
  assign frame_addr = s_reg.shift[6:0]; // (R23)
  assign frame_write = s_reg.shift[7]; // (R24)
  assign frame_data = s_reg.shift[15:8]; // (R23)
endmodule

// ===== dv/mode_supply_control_regs_sva.sv
// Port-level checks for the mode and supply control registers
`timescale 1ns/1ps
module mode_supply_control_regs_sva
  import supply_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic restart_entry,
  input wire logic overtemp_event,
  input wire logic overvoltage_event,
  input wire logic failure_status,
  input wire logic [1:0] op_mode,
  input wire logic soft_reset_active,
  input wire logic reset_output_oe,
  input wire logic aux_regulator_on,
  input wire logic main_overvoltage_flag,
  input wire logic overvoltage_restart_req,
  input wire logic fault_outputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] sr_cnt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sr_cnt_reg <= 8'h00;
    end else begin
      sr_cnt_reg <= soft_reset_active ? sr_cnt_reg + 8'h01 : 8'h00;
    end
  end
  sequence restart_clean;
    restart_entry ##1 !failure_status;
  endsequence
  a_ov_flag_set: assert property (overvoltage_event |=> main_overvoltage_flag)
    else $error("overvoltage flag not set");
  a_ov_req_cause: assert property (overvoltage_restart_req |-> $past(overvoltage_event))
    else $error("restart request without overvoltage");
  a_fault_follow: assert property (failure_status |-> fault_outputs)
    else $error("failure not on fault outputs");
  a_restart_normal: assert property (restart_entry |=> op_mode == 2'b00)
    else $error("restart left mode non-normal");
  a_aux_cleared: assert property ((restart_entry || overtemp_event) |=> !aux_regulator_on)
    else $error("aux regulator still on");
  a_stop_sleep: assert property (op_mode == 2'b10 && !restart_entry |=> op_mode != 2'b01)
    else $error("stop went to sleep");
  a_soft_len: assert property ($fell(soft_reset_active) |-> sr_cnt_reg == SOFT_RESET_COUNT)
    else $error("soft reset length wrong");
  a_reset_out_tie: assert property (reset_output_oe |-> soft_reset_active)
    else $error("reset output outside soft reset");
  a_fault_restart: assert property (restart_clean |-> !fault_outputs)
    else $error("fault outputs after restart");
endmodule
bind mode_supply_control_regs mode_supply_control_regs_sva u_sva (.clk, .nrst,
  .restart_entry, .overtemp_event, .overvoltage_event, .failure_status, .op_mode,
  .soft_reset_active, .reset_output_oe, .aux_regulator_on, .main_overvoltage_flag,
  .overvoltage_restart_req, .fault_outputs);

// ===== dv/serial_host_model.sv
// Host-side serial master issuing 16-bit frames
`timescale 1ns/1ps
module serial_host_model (
  input wire logic clk,
  output logic csn_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    csn_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Fewer than 16 bits makes a broken frame
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d,
                       input int n, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {d, w, a};
    rd = 8'h00;
    csn_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi <= bits[i];
      repeat (2) @(posedge clk);
      if (i > 7) rd[i-8] = sdo;
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    csn_n <= 1'b1;
    sdi <= ~sdi;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ===== dv/mode_supply_control_regs_tb.sv
// Self-checking bench for the mode and supply control registers
`timescale 1ns/1ps
module mode_supply_control_regs_tb;
  import supply_ctrl_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic restart_entry = 1'b0, overtemp_event = 1'b0, overvoltage_event = 1'b0;
  logic ov_flag_clear = 1'b0, failure_status = 1'b0, fail_safe_active = 1'b0;
  logic supply_undervoltage = 1'b0, high_power_active = 1'b0;
  logic csn_n, sclk, sdi, sdo, sdo_oe, soft_reset_active, reset_output_o, reset_output_oe;
  logic ext_pass_enable, ext_pass_voltage_select, ext_pass_load_share;
  logic load_share_stop_enable, aux_regulator_on, main_overvoltage_flag;
  logic overvoltage_restart_req, fault_outputs, wd_first_fail_select;
  logic [1:0] op_mode, reset_threshold_select;
  logic [7:0] mreg, hreg, rd, d;
  int error_cnt = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  serial_host_model u_host (.clk, .csn_n, .sclk, .sdi, .sdo);
  mode_supply_control_regs u_mode_supply_control_regs (.clk, .nrst, .csn_n, .sclk, .sdi,
    .sdo, .sdo_oe, .restart_entry, .overtemp_event, .overvoltage_event, .ov_flag_clear,
    .failure_status, .fail_safe_active, .supply_undervoltage, .high_power_active,
    .op_mode, .soft_reset_active, .reset_output_o, .reset_output_oe, .ext_pass_enable,
    .ext_pass_voltage_select, .ext_pass_load_share, .load_share_stop_enable,
    .aux_regulator_on, .reset_threshold_select, .main_overvoltage_flag,
    .overvoltage_restart_req, .fault_outputs, .wd_first_fail_select);
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] v, input int n = 16);
    u_host.frame(a, w, v, n, rd);
  endtask
  task automatic check_regs();
    xfer(MODE_SUPPLY_ADDR, 1'b0, 8'h00);
    `CHK(rd, mreg)
    xfer(HW_CONFIG_ADDR, 1'b0, 8'h00);
    `CHK(rd, hreg)
    `CHK({op_mode, reset_threshold_select}, {mreg[7:6], mreg[1:0]})
    `CHK({ext_pass_voltage_select, ext_pass_load_share}, {hreg[7], hreg[3]})
    `CHK(wd_first_fail_select, hreg[0])
    `CHK({reset_output_o, sdo_oe}, 2'b00)
  endtask
  function automatic logic aux_exp(input logic [7:0] m, input logic fs);
    case (m[4:3])
      2'b00: return 1'b0;
      2'b01: return m[7:6] == 2'b00;
      2'b10: return (m[7:6] == 2'b00) || (m[7:6] == 2'b10);
      default: return !fs;
    endcase
  endfunction
  function automatic logic [7:0] mode_after(input logic [7:0] cur, input logic [7:0] v);
    if (cur[7:6] == 2'b10 && v[7:6] == 2'b01) return {2'b10, v[5:0]};
    return v;
  endfunction
  task automatic wr_mode(input logic [7:0] v);
    xfer(MODE_SUPPLY_ADDR, 1'b1, v);
    `CHK(rd, mreg)
    mreg = mode_after(mreg, v);
  endtask
  task automatic wr_hw(input logic [7:0] v);
    xfer(HW_CONFIG_ADDR, 1'b1, v);
    `CHK(rd, hreg)
    hreg = v & 8'hfb;
  endtask
  task automatic close_out();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(25ns * 30000);
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(32'h4f4974ea));
    mreg = 8'h00;
    hreg = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check_regs();
    for (int i = 0; i < 20; i++) begin
      {fail_safe_active, supply_undervoltage, high_power_active} <= 3'($urandom);
      d = 8'($urandom);
      if (d[7:6] == 2'b11) d[7] = 1'b0;
      if (i[0]) wr_mode(d);
      else wr_hw(d);
      xfer(7'h05, 1'b0, d);
      `CHK(rd, 8'h00)
      xfer(MODE_SUPPLY_ADDR, 1'b1, ~d, 5 + i % 10);
      check_regs();
      `CHK(ext_pass_enable, mreg[5] && (!supply_undervoltage || hreg[4]))
      `CHK(load_share_stop_enable, hreg[3] && hreg[1] && ((mreg[7:6] == 2'b10) || high_power_active))
      `CHK(aux_regulator_on, aux_exp(mreg, fail_safe_active))
    end
    fail_safe_active <= 1'b0;
    wr_mode(8'h80);
    wr_mode(8'h5b);
    check_regs();
    for (int j = 0; j < 8; j++) begin
      wr_mode({j[2], 2'b00, j[1:0], 3'b000});
      `CHK(aux_regulator_on, j[1] || (j[0] && !j[2]))
    end
    wr_mode(8'h18);
    overtemp_event <= 1'b1;
    @(posedge clk);
    overtemp_event <= 1'b0;
    mreg = mreg & 8'he7;
    check_regs();
    wr_mode(8'h04);
    overvoltage_event <= 1'b1;
    @(posedge clk);
    overvoltage_event <= 1'b0;
    @(negedge clk);
    `CHK(overvoltage_restart_req, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(main_overvoltage_flag, 1'b1)
    ov_flag_clear <= 1'b1;
    @(posedge clk);
    ov_flag_clear <= 1'b0;
    `CHK(fault_outputs, hreg[5])
    wr_hw(8'h20);
    `CHK(main_overvoltage_flag, 1'b0)
    `CHK(fault_outputs, 1'b1)
    failure_status <= 1'b1;
    wr_hw(8'h00);
    `CHK(fault_outputs, 1'b1)
    wr_mode(8'hbf);
    wr_hw(8'hff);
    failure_status <= 1'b0;
    restart_entry <= 1'b1;
    @(posedge clk);
    restart_entry <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({fault_outputs, aux_regulator_on}, 2'b00)
    mreg = mreg & 8'h23;
    hreg = hreg & 8'hd9;
    check_regs();
    for (int b = 0; b < 2; b++) begin
      wr_hw({1'b1, b[0], 6'h19});
      xfer(MODE_SUPPLY_ADDR, 1'b1, 8'hc3);
      `CHK({soft_reset_active, reset_output_oe}, {1'b1, !b[0]})
      repeat (45) @(posedge clk);
      mreg = 8'h00;
      hreg = hreg & 8'hc9;
      check_regs();
    end
    close_out();
  end
endmodule
